/* core/mps_stretch.v */
// Reset pulse stretcher: holds a reset active a fixed time after its cause
`timescale 1ns/1ns
`include "mps_defines.vh"

module mps_stretch #(
  parameter [15:0] STRETCH_CYCLES = `MPS_T_RP_CYCLES
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Cause of reset, already on pclk
  input  wire cause,
  // Stretched reset, active high
  output wire active
);

  reg [15:0] cnt_q;     // Remaining stretch cycles
  reg        active_q;  // Registered reset output

  ////////////////////////////////////////////////////////////////////////////
  // Reload while the cause stands, count down once it clears. Comes out of
  // reset already active so the output never glitches inactive at power-up.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= STRETCH_CYCLES;
      active_q <= 1'b1;
    end else begin
      if (cause) begin
        cnt_q <= STRETCH_CYCLES;
      end else if (cnt_q != 16'h0000) begin
        cnt_q <= cnt_q - 16'h0001;
      end
      active_q <= cause | (cnt_q > 16'h0001);
    end
  end

  assign active = active_q;

endmodule

/* core/mps_supervisor.v */
// Pin supervisor: resets, fan pins, thermal and GENERAL_LOGIC_INPUT pins, bus pins, APB regs
`timescale 1ns/1ns
`include "mps_defines.vh"

module mps_supervisor #(
  parameter [15:0] STRETCH_CYCLES = `MPS_T_RP_CYCLES
) (
  // Clock and reset (presetn acts as power-on reset)
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata,
  // Supply comparators (asynchronous levels)
  input  wire        vcc_below_thr,
  input  wire        second_supply_sense_low,
  // Manual reset pin
  input  wire        manual_reset_n,
  // Primary reset open-drain pin
  input  wire        primary_reset_n_in,
  output wire        primary_reset_n_out,
  output wire        primary_reset_n_oe,
  // Device reset request from the primary reset pin
  output wire        device_reset_req,
  // Secondary reset open-drain pin
  output wire        secondary_reset_n_out,
  output wire        secondary_reset_n_oe,
  // Fan off request open-drain pin and its internal cause
  input  wire        fan_off_request,
  output wire        fan_off_n_out,
  output wire        fan_off_n_oe,
  // Fan speed analog output / test enable pin
  input  wire        fan_speed_out_test_enable,
  output wire [7:0]  fan_speed_code,
  output wire        nand_test_mode,
  // Address select pin: two sensed levels, plus test output drive
  input  wire        bus_id_pin_hi,
  input  wire        bus_id_pin_lo,
  output wire        bus_id_pin_test_out,
  output wire        bus_id_pin_test_oe,
  output wire [6:0]  bus_address,
  // Diode2 negative / thermal open-drain pin
  input  wire        diode2_neg_in,
  output wire        diode2_neg_out,
  output wire        diode2_neg_oe,
  input  wire        over_temp_event,
  // Diode2 positive / general logic input pin
  input  wire        diode2_pos_in,
  output wire        diode2_neg_analog,
  output wire        diode2_pos_analog,
  // Interrupt open-drain pin and its cause
  input  wire        trip_violation,
  output wire        int_n_out,
  output wire        int_n_oe,
  // Management bus pins and engine side
  input  wire        bus_clk_in,
  input  wire        bus_data_in,
  input  wire        bus_data_drive_low,
  output wire        bus_data_out,
  output wire        bus_data_oe,
  output wire        bus_clk_sync,
  output wire        bus_data_sync
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: one generate loop, stage one feeds stage two only

  localparam NSYNC = 10;
  wire [NSYNC-1:0] pin_raw;   // Raw asynchronous pin levels
  wire [NSYNC-1:0] pin_s;     // Second-stage synchronised levels
  // Reset levels: pins idle high, test enable off so no address pin drive
  localparam [NSYNC-1:0] SYNC_RST = 10'h3f7;

  assign pin_raw = {bus_data_in, bus_clk_in, diode2_pos_in, diode2_neg_in,
                    bus_id_pin_lo, bus_id_pin_hi, fan_speed_out_test_enable,
                    primary_reset_n_in, manual_reset_n,
                    second_supply_sense_low};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      reg s1_q;  // First stage, read only by s2_q
      reg s2_q;  // Second stage, safe to use
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= SYNC_RST[gi];
          s2_q <= SYNC_RST[gi];
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
        end
      end
      assign pin_s[gi] = s2_q;
    end
  endgenerate

  // Main supply comparator synchronised separately: resets to low-supply
  reg vcc_s1_q;   // First stage
  reg vcc_low_q;  // Second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcc_s1_q  <= 1'b1;
      vcc_low_q <= 1'b1;
    end else begin
      vcc_s1_q  <= vcc_below_thr;
      vcc_low_q <= vcc_s1_q;
    end
  end

  // Names for the synchronised pins
  wire supply2_low_s = pin_s[0];
  wire mr_n_s        = pin_s[1];
  wire prim_n_s      = pin_s[2];
  wire test_en_s     = pin_s[3];
  wire addr_hi_s     = pin_s[4];
  wire addr_lo_s     = pin_s[5];
  wire d2neg_s       = pin_s[6];
  wire d2pos_s       = pin_s[7];
  wire scl_s         = pin_s[8];
  wire sda_s         = pin_s[9];

  ////////////////////////////////////////////////////////////////////////////
  // Reset generators

  wire prim_active;  // Primary reset, stretched
  wire sec_active;   // Secondary reset, stretched
  wire sec_cause;    // Any secondary reset cause

  // Primary reset follows the main supply only
  mps_stretch #(
    .STRETCH_CYCLES (STRETCH_CYCLES)
  ) u_prim (
    .pclk    (pclk),
    .presetn (presetn),
    .cause   (vcc_low_q),
    .active  (prim_active)
  );

  // Secondary reset: the pin sensed low covers both our own drive and an
  // external pull, so either keeps the secondary reset asserted
  assign sec_cause = supply2_low_s | vcc_low_q | ~mr_n_s | ~prim_n_s;

  mps_stretch #(
    .STRETCH_CYCLES (STRETCH_CYCLES)
  ) u_sec (
    .pclk    (pclk),
    .presetn (presetn),
    .cause   (sec_cause),
    .active  (sec_active)
  );

  // Open-drain: output always low, enable when asserting
  assign primary_reset_n_out   = 1'b0;
  assign primary_reset_n_oe    = prim_active;
  assign secondary_reset_n_out = 1'b0;
  assign secondary_reset_n_oe  = sec_active;
  // Auxiliary reset gating when driven externally is left to board logic
  assign device_reset_req      = ~prim_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Fan off request: same-clock input, so no synchroniser
  reg fan_off_q;  // Registered request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_off_q <= 1'b0;
    end else begin
      fan_off_q <= fan_off_request;
    end
  end
  assign fan_off_n_out = 1'b0;
  assign fan_off_n_oe  = fan_off_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers held by software

  reg  [4:0]  cfg_q;      // Configuration
  reg  [7:0]  fanspd_q;   // Fan speed code
  reg         st_gpi_q;   // Sticky general input status
  reg         st_therm_q; // Sticky external thermal status
  reg  [31:0] rdata_q;    // Read data captured in setup phase

  wire int_en    = cfg_q[`MPS_CFG_INT_EN];
  wire d2neg_dig = cfg_q[`MPS_CFG_D2NEG_DIG];
  wire d2pos_dig = cfg_q[`MPS_CFG_D2POS_DIG];
  wire gpi_pol   = cfg_q[`MPS_CFG_GPI_POL];

  // APB decode
  wire setup_ph = psel & ~penable;
  wire acc_ph   = psel & penable;
  wire hit_cfg  = (paddr == `MPS_REG_CONFIG);
  wire hit_st   = (paddr == `MPS_REG_STATUS);
  wire hit_pin  = (paddr == `MPS_REG_PINS);
  wire hit_fan  = (paddr == `MPS_REG_FANSPD);
  wire mapped   = hit_cfg | hit_st | hit_pin | hit_fan;
  wire wr_acc   = acc_ph & pwrite & mapped;
  // Read of the status register clears sticky bits at the access edge
  wire st_read  = acc_ph & ~pwrite & hit_st;

  ////////////////////////////////////////////////////////////////////////////
  // Thermal and general input pins

  // External pull is only seen once our own release has reached the synced
  // pin; otherwise the tail of our own drive would look external
  reg  [2:0] therm_drv_q;                           // Own drive, now and 2 back
  wire therm_ext = d2neg_dig & ~d2neg_s & ~(|therm_drv_q);
  // General input active level per polarity bit (1 = active high)
  wire gpi_act   = d2pos_dig & (gpi_pol ? d2pos_s : ~d2pos_s);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_drv_q <= 3'h0;
    end else begin
      therm_drv_q <= {therm_drv_q[1:0], d2neg_dig & over_temp_event};
    end
  end
  assign diode2_neg_out    = 1'b0;
  assign diode2_neg_oe     = therm_drv_q[0];
  // Analog front-end switches stay on while the pin is in diode mode
  assign diode2_neg_analog = ~d2neg_dig;
  assign diode2_pos_analog = ~d2pos_dig;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and sticky status; set wins over a clearing read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q      <= `MPS_CFG_RESET;
      fanspd_q   <= `MPS_FANSPD_RESET;
      st_gpi_q   <= 1'b0;
      st_therm_q <= 1'b0;
    end else begin
      if (wr_acc && hit_cfg) begin
        cfg_q <= pwdata[4:0];
      end
      if (wr_acc && hit_fan) begin
        fanspd_q <= pwdata[7:0];
      end
      // Cleared by a read only while the input is inactive
      if (gpi_act) begin
        st_gpi_q <= 1'b1;
      end else if (st_read) begin
        st_gpi_q <= 1'b0;
      end
      if (therm_ext) begin
        st_therm_q <= 1'b1;
      end else if (st_read) begin
        st_therm_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fan speed output: forced full while an external thermal pull stands
  reg [7:0] fan_code_q;  // Registered DAC code
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_code_q <= `MPS_FANSPD_RESET;
    end else if (therm_ext) begin
      fan_code_q <= `MPS_FANSPD_FULL;
    end else begin
      fan_code_q <= fanspd_q;
    end
  end
  assign fan_speed_code = fan_code_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus address: address pin captured once after power-up settling

  reg [1:0] settle_q;    // Settling count
  reg       captured_q;  // Address taken
  reg [1:0] addr_lo_q;   // Low address bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q   <= 2'h0;
      captured_q <= 1'b0;
      addr_lo_q  <= `MPS_ADDR_LO_OPEN;
    end else if (!captured_q) begin
      if (settle_q != `MPS_ADDR_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end else begin
        captured_q <= 1'b1;
        // Neither comparator tripped means the pin floats
        if (addr_lo_s) begin
          addr_lo_q <= `MPS_ADDR_LO_GND;
        end else if (addr_hi_s) begin
          addr_lo_q <= `MPS_ADDR_LO_VCC;
        end else begin
          addr_lo_q <= `MPS_ADDR_LO_OPEN;
        end
      end
    end
  end
  assign bus_address = {`MPS_BUS_ADDR_HI, addr_lo_q};

  ////////////////////////////////////////////////////////////////////////////
  // NAND test: chain of the digital inputs shown on the address pin.
  // Fan speed output is an analog pin; the test only changes its use here.
  reg nand_q;  // Registered tree output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nand_q <= 1'b0;
    end else begin
      nand_q <= ~(mr_n_s & prim_n_s & d2pos_s & d2neg_s & scl_s & sda_s);
    end
  end
  assign nand_test_mode      = test_en_s;
  assign bus_id_pin_test_out = nand_q;
  assign bus_id_pin_test_oe  = test_en_s;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output, disabled after reset
  reg int_q;  // Registered interrupt drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 1'b0;
    end else begin
      int_q <= int_en & trip_violation;
    end
  end
  assign int_n_out = 1'b0;
  assign int_n_oe  = int_q;

  ////////////////////////////////////////////////////////////////////////////
  // Management bus pins: clock is input only, data open-drain
  assign bus_clk_sync  = scl_s;
  assign bus_data_sync = sda_s;
  assign bus_data_out  = 1'b0;
  assign bus_data_oe   = bus_data_drive_low;

  ////////////////////////////////////////////////////////////////////////////
  // APB read data, captured in the setup phase so prdata is registered.
  // Status seen is the value before any clear at the access edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      rdata_q <= 32'h0000_0000;
      if (hit_cfg) begin
        rdata_q[4:0] <= cfg_q;
      end
      if (hit_st) begin
        rdata_q[`MPS_ST_GPI]   <= st_gpi_q | gpi_act;
        rdata_q[`MPS_ST_THERM] <= st_therm_q | therm_ext;
      end
      if (hit_pin) begin
        rdata_q[6:0]  <= bus_address;
        rdata_q[7]    <= test_en_s;
        rdata_q[8]    <= prim_active;
        rdata_q[9]    <= sec_active;
        rdata_q[10]   <= d2pos_s;
        rdata_q[11]   <= d2neg_s;
      end
      if (hit_fan) begin
        rdata_q[7:0] <= fanspd_q;
      end
    end
  end

  // Zero wait states; unmapped offsets answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~mapped;
  assign prdata  = rdata_q;

endmodule

/* pkg/mps_defines.vh */
// Constants shared by the pin supervisor: offsets, fields, resets, timing
`ifndef MPS_DEFINES_VH
`define MPS_DEFINES_VH

// Clock period of pclk in ns
`define MPS_CLK_PERIOD_NS      10
// Reset pulse stretch time in ns (plain default, no figure is given)
`define MPS_T_RP_NS            1000
// Stretch time as whole pclk cycles, rounded up, zero for a zero time
`define MPS_T_RP_CYCLES        ((`MPS_T_RP_NS + `MPS_CLK_PERIOD_NS - 1) / `MPS_CLK_PERIOD_NS)
// Cycles the address pin is synchronised before capture after power-up
`define MPS_ADDR_SETTLE        2'h3

// Register byte offsets on APB
`define MPS_REG_CONFIG         8'h00
`define MPS_REG_STATUS         8'h04
`define MPS_REG_PINS           8'h08
`define MPS_REG_FANSPD         8'h0c

// Configuration register fields
`define MPS_CFG_INT_EN         1
`define MPS_CFG_D2NEG_DIG      2
`define MPS_CFG_D2POS_DIG      3
`define MPS_CFG_GPI_POL        4
`define MPS_CFG_RESET          5'h00

// Status register fields
`define MPS_ST_GPI             4
`define MPS_ST_THERM           5

// Fan speed register reset value and full-on code
`define MPS_FANSPD_RESET       8'h00
`define MPS_FANSPD_FULL        8'hff

// Fixed upper five bits of the bus address
`define MPS_BUS_ADDR_HI        5'h0b
// Low address bits per address pin state
`define MPS_ADDR_LO_GND        2'h2
`define MPS_ADDR_LO_OPEN       2'h0
`define MPS_ADDR_LO_VCC        2'h1

`endif

/* tb/mps_reset_host.sv */
// Far-side reset logic model: primary reset wire and auxiliary reset
`timescale 1ns/1ns
module mps_reset_host (
  // Device drive of the primary reset wire
  input  wire primary_reset_n_oe,
  // Bench commands: pull the wire as an input, own aux cause
  input  wire ext_pull,
  input  wire aux_cause,
  // Resolved wire and the system auxiliary reset
  output wire primary_reset_n,
  output wire aux_reset
);
  // Open drain with pull-up: anyone may pull it low
  assign primary_reset_n = !(primary_reset_n_oe | ext_pull);
  // Our own pull of the wire trips the aux reset unless an external pull stands
  assign aux_reset = aux_cause | (primary_reset_n_oe & !ext_pull);
endmodule

/* tb/mps_supervisor_sva.sv */
// Checker for the supervisor's reset, fan, thermal and bus pins
`timescale 1ns/1ns
module mps_supervisor_sva #(
  parameter [15:0] STRETCH_CYCLES = 16'h0008
) (
  // Clock and reset
  input wire       pclk,
  input wire       presetn,
  // Reset causes and reset pins
  input wire       vcc_below_thr,
  input wire       second_supply_sense_low,
  input wire       manual_reset_n,
  input wire       primary_reset_n_in,
  input wire       primary_reset_n_oe,
  input wire       device_reset_req,
  input wire       secondary_reset_n_oe,
  // Fan, thermal, address, interrupt and bus pins
  input wire       fan_off_request,
  input wire       fan_off_n_oe,
  input wire       fan_speed_out_test_enable,
  input wire       nand_test_mode,
  input wire       bus_id_pin_test_oe,
  input wire [7:0] fan_speed_code,
  input wire [6:0] bus_address,
  input wire       diode2_neg_in,
  input wire       diode2_neg_oe,
  input wire       diode2_neg_analog,
  input wire       over_temp_event,
  input wire       trip_violation,
  input wire       int_n_oe,
  input wire       bus_data_drive_low,
  input wire       bus_data_oe
);
  reg  [15:0] sec_q; // Quiet cycles since any secondary cause
  reg  [15:0] pri_q; // Quiet cycles since main supply low
  reg  [3:0]  up_q;  // Cycles since reset release, saturating
  wire        sec_cause;
  assign sec_cause = vcc_below_thr | second_supply_sense_low |
                     !manual_reset_n | !primary_reset_n_in;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // Raw causes are counted, so sync delay adds margin to the MIN checks and uses up part of the MAX slack
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= 16'h0000;
      pri_q <= 16'h0000;
      up_q  <= 4'h0;
    end else begin
      sec_q <= sec_cause ? 16'h0000 : sec_q + (sec_q != 16'hffff);
      pri_q <= vcc_below_thr ? 16'h0000 : pri_q + (pri_q != 16'hffff);
      up_q  <= up_q + (up_q != 4'hf);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  AST_MR_HOLD: assert property (!manual_reset_n [*5] |->
    secondary_reset_n_oe) else $error("secondary reset not held");
  AST_VCC_HOLD: assert property (vcc_below_thr [*5] |->
    primary_reset_n_oe && secondary_reset_n_oe) else $error("vcc hold");
  AST_PRIM_IN: assert property (!primary_reset_n_in [*5] |->
    device_reset_req && secondary_reset_n_oe) else $error("prim input");
  AST_SEC_MIN: assert property ($fell(secondary_reset_n_oe) |->
    sec_q >= STRETCH_CYCLES) else $error("secondary released early");
  AST_SEC_MAX: assert property (sec_q == STRETCH_CYCLES + 8 |->
    !secondary_reset_n_oe) else $error("secondary released late");
  AST_PRI_MIN: assert property ($fell(primary_reset_n_oe) |->
    pri_q >= STRETCH_CYCLES) else $error("primary released early");
  AST_PRI_MAX: assert property (pri_q == STRETCH_CYCLES + 8 |->
    !primary_reset_n_oe) else $error("primary released late");
  AST_FAN_OFF: assert property (fan_off_n_oe ==
    $past(fan_off_request)) else $error("fan off request lag");
  AST_TEST_EN: assert property (fan_speed_out_test_enable [*4] |->
    nand_test_mode && bus_id_pin_test_oe) else $error("test mode");
  AST_ADDR_HI: assert property (bus_address[6:2] == 5'h0b)
    else $error("address upper bits");
  AST_ADDR_HOLD: assert property (up_q == 4'hf |->
    $stable(bus_address)) else $error("address changed");
  AST_THERM_OUT: assert property (over_temp_event &&
    !diode2_neg_analog |=> diode2_neg_oe) else $error("thermal drive");
  AST_THERM_IN: assert property ((!diode2_neg_analog &&
    !diode2_neg_oe && !diode2_neg_in) [*5] |-> fan_speed_code == 8'hff)
    else $error("fan not full");
  AST_INT: assert property (int_n_oe |-> $past(trip_violation))
    else $error("interrupt without cause");
  AST_SDA: assert property (bus_data_oe == bus_data_drive_low)
    else $error("data pin drive");
endmodule
bind mps_supervisor mps_supervisor_sva
  #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_sva (.*);

/* tb/test_mps_supervisor.sv */
// Self-checking bench for the pin supervisor over APB and its pins
`timescale 1ns/1ns
module test_mps_supervisor;
  localparam [15:0] S = 16'h0008; // Shortened stretch for simulation
  reg pclk, presetn, psel, penable, pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata, rdat;
  wire pready, pslverr;
  wire [31:0] prdata;
  reg vcc_below_thr, second_supply_sense_low, manual_reset_n, serr;
  reg fan_off_request, fan_speed_out_test_enable, bus_id_pin_hi;
  reg bus_id_pin_lo, over_temp_event, diode2_pos_in, trip_violation;
  reg bus_clk_in, bus_data_drive_low, ext_pull, therm_pull;
  wire primary_reset_n_in, primary_reset_n_out, primary_reset_n_oe;
  wire device_reset_req, secondary_reset_n_out, secondary_reset_n_oe;
  wire fan_off_n_out, fan_off_n_oe, nand_test_mode, bus_id_pin_test_out;
  wire bus_id_pin_test_oe, diode2_neg_out, diode2_neg_oe, diode2_neg_in;
  wire diode2_neg_analog, diode2_pos_analog, int_n_out, int_n_oe;
  wire bus_data_out, bus_data_oe, bus_clk_sync, bus_data_sync;
  wire bus_data_in, aux_reset;
  wire [7:0] fan_speed_code;
  wire [6:0] bus_address;
  integer err_total, n_checks, i, k;
  // Open-drain wires with pull-ups, resolved from every driver
  assign diode2_neg_in = !(diode2_neg_oe | therm_pull);
  assign bus_data_in = !bus_data_oe;
  mps_supervisor #(.STRETCH_CYCLES(S)) dut (.*);
  mps_reset_host u_host (
    .primary_reset_n_oe(primary_reset_n_oe),
    .ext_pull          (ext_pull),
    .aux_cause         (1'b0),
    .primary_reset_n   (primary_reset_n_in),
    .aux_reset         (aux_reset)
  );
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, entered just after a rising edge
  task apb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        t = t + 1;
        if (t > 20) begin
          err_total = err_total + 1;
          give_verdict;
        end
        @(posedge pclk);
      end
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rst;
    begin
      presetn <= 1'b0;
      cyc(8);
      presetn <= 1'b1;
      cyc(40);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {vcc_below_thr, second_supply_sense_low, fan_off_request} = 0;
    {fan_speed_out_test_enable, bus_id_pin_hi, bus_id_pin_lo} = 0;
    {over_temp_event, diode2_pos_in, trip_violation} = 0;
    {bus_data_drive_low, ext_pull, therm_pull, serr, rdat} = 0;
    {manual_reset_n, bus_clk_in} = 2'h3;
    {err_total, n_checks} = 0;
    // Address pin open, grounded, at supply across power-ups
    for (i = 0; i < 3; i = i + 1) begin
      bus_id_pin_lo <= (i == 1);
      bus_id_pin_hi <= (i == 2);
      rst;
      chk(bus_address, {5'h0b, i == 1, i == 2});
      bus_id_pin_lo <= !bus_id_pin_lo;
      cyc(6);
      chk(bus_address, {5'h0b, i == 1, i == 2});
    end
    $display("test address done");
    apb(0, 8'h00, 0);
    chk(rdat[4:0], 5'h00);
    apb(0, 8'h08, 0);
    chk(rdat[6:0], 7'h2d);
    apb(0, 8'h10, 0);
    chk({serr, rdat}, {1'b1, 32'h0});
    trip_violation <= 1'b1;
    cyc(3);
    chk(int_n_oe, 0);
    apb(1, 8'h00, 32'h2);
    cyc(2);
    chk(int_n_oe, 1);
    trip_violation <= 1'b0;
    fan_off_request <= 1'b1;
    cyc(2);
    chk({fan_off_n_oe, fan_off_n_out}, 2'h2);
    chk({primary_reset_n_out, secondary_reset_n_out}, 2'h0);
    chk({diode2_neg_out, int_n_out}, 2'h0);
    fan_off_request <= 1'b0;
    apb(1, 8'h0c, 32'h5a);
    cyc(1);
    chk(fan_speed_code, 8'h5a);
    $display("test regs done");
    // Thermal pin: own drive, then an external pull
    apb(1, 8'h00, 32'h6);
    chk(diode2_neg_analog, 0);
    over_temp_event <= 1'b1;
    cyc(2);
    chk(diode2_neg_oe, 1);
    over_temp_event <= 1'b0;
    cyc(3);
    therm_pull <= 1'b1;
    cyc(6);
    chk(fan_speed_code, 8'hff);
    apb(0, 8'h04, 0);
    chk(rdat[5], 1);
    therm_pull <= 1'b0;
    // General input: sticky bit, clear only while inactive
    apb(1, 8'h00, 32'h1e);
    chk(diode2_pos_analog, 0);
    diode2_pos_in <= 1'b1;
    cyc(4);
    apb(0, 8'h04, 0);
    chk(rdat[4], 1);
    diode2_pos_in <= 1'b0;
    cyc(4);
    apb(0, 8'h04, 0);
    chk(rdat[4], 1);
    apb(0, 8'h04, 0);
    chk(rdat[4], 0);
    apb(1, 8'h00, 32'h0e);
    cyc(4);
    apb(0, 8'h04, 0);
    chk(rdat[4], 1);
    $display("test thermal gpi done");
    ext_pull <= 1'b1;
    cyc(6);
    chk({device_reset_req, secondary_reset_n_oe}, 2'h3);
    chk(aux_reset, 0);
    ext_pull <= 1'b0;
    cyc(40);
    // Manual, second supply and main supply causes, then stretch
    for (i = 0; i < 3; i = i + 1) begin
      manual_reset_n <= (i != 0);
      second_supply_sense_low <= (i == 1);
      vcc_below_thr <= (i == 2);
      cyc(10);
      chk(secondary_reset_n_oe, 1);
      if (i == 2)
        chk(primary_reset_n_oe, 1);
      manual_reset_n <= 1'b1;
      {second_supply_sense_low, vcc_below_thr} <= 2'h0;
      k = 0;
      while (secondary_reset_n_oe !== 1'b0 && k < 200) begin
        cyc(1);
        k = k + 1;
      end
      chk(k >= S * (1 + (i == 2)) && k <= S * (1 + (i == 2)) + 12, 1);
      if (k >= 200)
        give_verdict;
    end
    $display("test resets done");
    diode2_pos_in <= 1'b1;
    fan_speed_out_test_enable <= 1'b1;
    cyc(5);
    chk({nand_test_mode, bus_id_pin_test_oe}, 2'h3);
    chk(bus_id_pin_test_out, 0);
    bus_clk_in <= 1'b0;
    bus_data_drive_low <= 1'b1;
    cyc(5);
    chk(bus_id_pin_test_out, 1);
    chk({bus_data_oe, bus_data_out, bus_data_sync}, 3'h4);
    chk(bus_clk_sync, 0);
    $display("test pins done");
    give_verdict;
  end
endmodule
